// ==== scrsm_cfg.svh ====
// Constants of the subcode readout and status multiplexer.
// Assumes a 100 MHz system clock; included by scrsm_top, scrsm_checker and scrsm_top_tb.
`ifndef SCRSM_CFG_SVH
`define SCRSM_CFG_SVH

// =====================================================================
// Timing
`define SCRSM_CLK_PERIOD_NS 10
// Monostable time, inside the 270 to 400 us window
`define SCRSM_MONO_TIME_NS 335000
`define SCRSM_MONO_CYCLES (`SCRSM_MONO_TIME_NS / `SCRSM_CLK_PERIOD_NS)
`define SCRSM_MONO_CNT_W 16

// =====================================================================
// Subcode Q block layout
`define SCRSM_Q_DATA_BITS 80
`define SCRSM_Q_BLOCK_BITS 96
`define SCRSM_Q_CNT_W 7
`define SCRSM_Q_LAST_BIT 7'h5F
`define SCRSM_Q_DATA_END 7'h50
`define SCRSM_CRC_POLY 16'h1021
`define SCRSM_CRC_INIT 16'h0000

// =====================================================================
// Status command nibbles
`define SCRSM_CMD_SENSE0 4'h0
`define SCRSM_CMD_SENSE1 4'h1
`define SCRSM_CMD_SENSE2 4'h2
`define SCRSM_CMD_SENSE3 4'h3
`define SCRSM_CMD_BUSY 4'h4
`define SCRSM_CMD_FOCUS 4'h5
`define SCRSM_CMD_SENSE6 4'h6
`define SCRSM_CMD_SYNC 4'hA
`define SCRSM_CMD_LONG 4'hE

// =====================================================================
// P-W symbol width and multiplexed slot counter width
`define SCRSM_PW_BITS 8
`define SCRSM_SLOT_W 2

`endif

// ==== scrsm_pkg.sv ====
// Types of the subcode readout and status multiplexer.
// Assumes scrsm_cfg.svh holds all numeric constants.
package scrsm_pkg;

   // ==================================================================
   // Q readout state, one-hot
   typedef enum logic [1:0] {
      SCRSM_Q_IDLE = 2'b01,
      SCRSM_Q_SHIFT = 2'b10
   } scrsm_qstate_t;

   // ==================================================================
   // Routing of the Q serial output pin
   typedef enum logic [1:0] {
      SCRSM_OUT_QDATA = 2'b00,
      SCRSM_OUT_PW = 2'b01,
      SCRSM_OUT_STATUS = 2'b10,
      SCRSM_OUT_MUX = 2'b11
   } scrsm_outsel_t;

endpackage

// ==== scrsm_sync.sv ====
// Two-stage synchroniser for levels entering the system clock domain.
// Assumes each bit is a level or gray-coded with the others.
`timescale 1ns/1ps
module scrsm_sync #(
   parameter int WIDTH = 1
) (
   // Clock, reset and enable
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   // Data
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_q <= '0;
         q_o <= '0;
      end else if (ce_i) begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end

endmodule

// ==== scrsm_pw_link.sv ====
// Bit position counter of the P-W readout, on the host shift clock.
// Assumes the host gives eight edges per symbol; output is gray coded.
`timescale 1ns/1ps
module scrsm_pw_link (
   // Link clock and reset
   input wire logic pw_shift_clock_i,
   input wire logic resetn_i,
   // Position, gray coded
   output logic [2:0] pos_gray_o
);

   logic [2:0] pos_q;
   logic [2:0] pos_d;

   assign pos_d = pos_q + 3'h1;

   // One bit position per rising edge of the external clock
   always_ff @(posedge pw_shift_clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pos_q <= 3'h0;
         pos_gray_o <= 3'h0;
      end else begin
         pos_q <= pos_d; // [R9]
         pos_gray_o <= pos_d ^ (pos_d >> 1);
      end
   end

endmodule

// ==== scrsm_top.sv ====
// Subcode readout and status multiplexer of a disc signal processor.
// Assumes same-clock sources for command bits, subcode bits and flags;
// sense, focus and both shift clocks arrive on pins.
`timescale 1ns/1ps
`include "scrsm_cfg.svh"

// What this block does
// (R1) Nibbles 0,1,2,3,6 send servo sense input
// (R2) Nibble 4 sends sequencer busy flag
// (R3) Nibble 5 sends focus ok pin
// (R4) Nibble A sends frame sync good
// (R5) Nibble E sends long pulse flag
// (R6) Other nibbles hold sense output low
// (R7) Selection follows nibble without any latch
// (R8) Select 10 puts sense on Q pin
// (R9) P-W symbol shifted one bit per rising edge
// (R10) Host clocks P-W right after frame fall
// (R11) Select 01 puts P-W data on Q pin
// (R12) Q bits feed 80-bit register and CRC
// (R13) CRC pass raises flag, loads shadow
// (R14) Bits reversed within each loaded byte
// (R15) Host checks flags, gives 80 clocks
// (R16) Flag rises at least 335 us later
// (R17) Q shift edges retrigger monostable blocking loads
// (R18) Fast readout never overwritten by new word
// (R19) Host keeps clock phases 750 ns-120 us
// (R20) Select 11 multiplexes outputs, Q clocked
// (R21) Monostable is counter cleared by edges
module scrsm_top #(
   parameter int MONO_CYCLES = `SCRSM_MONO_CYCLES,
   parameter int DATA_BITS = `SCRSM_Q_DATA_BITS
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   // Command register
   input wire logic [3:0] cmd_nibble_i,
   input wire logic out_select_hi_i,
   input wire logic out_select_lo_i,
   // Status sources
   input wire logic servo_sense_in_i,
   input wire logic focus_ok_i,
   input wire logic sequencer_busy_n_i,
   input wire logic frame_sync_good_i,
   input wire logic long_pulse_flag_n_i,
   // Subcode from the demodulator
   input wire logic [`SCRSM_PW_BITS-1:0] pw_symbol_i,
   input wire logic pw_symbol_load_i,
   input wire logic q_bit_i,
   input wire logic q_bit_valid_i,
   input wire logic q_block_start_i,
   // Host shift clocks
   input wire logic pw_shift_clock_i,
   input wire logic q_shift_clock_i,
   // Host facing outputs
   output logic status_select_out_o,
   output logic pw_serial_out_o,
   output logic q_serial_out_o,
   output logic crc_pass_flag_o,
   output logic subcode_sync_flag_o
);

   // ==================================================================
   // Pin synchronisers
   logic [2:0] pins_s;
   logic sense_s;
   logic focus_s;
   logic qclk_s;
   logic qclk_prev_q;
   logic qclk_rise;
   logic qclk_edge;

   scrsm_sync #(
      .WIDTH(3)
   ) u_pin_sync (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .d_i({q_shift_clock_i, focus_ok_i, servo_sense_in_i}),
      .q_o(pins_s)
   );

   assign sense_s = pins_s[0];
   assign focus_s = pins_s[1];
   assign qclk_s = pins_s[2];

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         qclk_prev_q <= 1'b0;
      end else if (ce_i) begin
         qclk_prev_q <= qclk_s;
      end
   end

   assign qclk_edge = qclk_s ^ qclk_prev_q;
   assign qclk_rise = qclk_s & ~qclk_prev_q;

   // ==================================================================
   // Status multiplexer
   logic status_d;

   always_comb begin
      case (cmd_nibble_i) // [R7]
         `SCRSM_CMD_SENSE0,
         `SCRSM_CMD_SENSE1,
         `SCRSM_CMD_SENSE2,
         `SCRSM_CMD_SENSE3,
         `SCRSM_CMD_SENSE6: begin
            status_d = sense_s; // [R1]
         end
         `SCRSM_CMD_BUSY: begin
            status_d = sequencer_busy_n_i; // [R2]
         end
         `SCRSM_CMD_FOCUS: begin
            status_d = focus_s; // [R3]
         end
         `SCRSM_CMD_SYNC: begin
            status_d = frame_sync_good_i; // [R4]
         end
         `SCRSM_CMD_LONG: begin
            status_d = long_pulse_flag_n_i; // [R5]
         end
         default: begin
            status_d = 1'b0; // [R6]
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         status_select_out_o <= 1'b0;
      end else if (ce_i) begin
         status_select_out_o <= status_d;
      end
   end

   // ==================================================================
   // P-W symbol readout
   logic [`SCRSM_PW_BITS-1:0] pw_sym_q;
   logic [2:0] pw_gray;
   logic [2:0] pw_gray_s;
   logic [2:0] pw_pos;

   scrsm_pw_link u_pw_link (
      .pw_shift_clock_i(pw_shift_clock_i),
      .resetn_i(resetn_i),
      .pos_gray_o(pw_gray)
   );

   scrsm_sync #(
      .WIDTH(3)
   ) u_pw_sync (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .d_i(pw_gray),
      .q_o(pw_gray_s)
   );

   assign pw_pos[2] = pw_gray_s[2];
   assign pw_pos[1] = pw_gray_s[2] ^ pw_gray_s[1];
   assign pw_pos[0] = pw_gray_s[2] ^ pw_gray_s[1] ^ pw_gray_s[0];

   // Symbol held steady for the whole frame the host reads in
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pw_sym_q <= '0;
      end else if (ce_i && pw_symbol_load_i) begin
         pw_sym_q <= pw_symbol_i; // [R10]
      end
   end

   // Most significant bit (P) leaves first
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pw_serial_out_o <= 1'b0;
      end else if (ce_i) begin
         pw_serial_out_o <= pw_sym_q[3'h7 - pw_pos]; // [R9]
      end
   end

   // ==================================================================
   // Q reception and CRC check
   logic [DATA_BITS-1:0] sp_q;
   logic [DATA_BITS-1:0] hold_q;
   logic [`SCRSM_Q_CNT_W-1:0] qcnt_q;
   logic [15:0] crc_q;
   logic [15:0] crc_rx_q;
   logic crc_fb;
   logic block_done;
   logic crc_good;

   assign crc_fb = q_bit_i ^ crc_q[15];
   assign block_done = q_bit_valid_i && (qcnt_q == `SCRSM_Q_LAST_BIT);
   assign crc_good = (crc_q == ~{crc_rx_q[14:0], q_bit_i});

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         qcnt_q <= '0;
      end else if (ce_i) begin
         if (q_block_start_i) begin
            qcnt_q <= '0;
         end else if (block_done) begin
            qcnt_q <= '0;
         end else if (q_bit_valid_i) begin
            qcnt_q <= qcnt_q + 7'h01;
         end
      end
   end

   // First bit received ends up at index 0
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sp_q <= '0;
         crc_q <= `SCRSM_CRC_INIT;
         crc_rx_q <= '0;
      end else if (ce_i && q_bit_valid_i) begin
         if (qcnt_q < `SCRSM_Q_DATA_END) begin
            sp_q <= {q_bit_i, sp_q[DATA_BITS-1:1]}; // [R12]
            crc_q <= {crc_q[14:0], 1'b0} ^
                     (crc_fb ? `SCRSM_CRC_POLY : 16'h0000); // [R12]
            crc_rx_q <= '0;
         end else if (block_done) begin
            crc_q <= `SCRSM_CRC_INIT;
         end else begin
            crc_rx_q <= {crc_rx_q[14:0], q_bit_i};
         end
      end
   end

   // ==================================================================
   // Monostable, retriggered by every Q shift clock edge
   logic [`SCRSM_MONO_CNT_W-1:0] mono_q;
   logic mono_busy;

   assign mono_busy = (mono_q != MONO_CYCLES[`SCRSM_MONO_CNT_W-1:0]);

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mono_q <= MONO_CYCLES[`SCRSM_MONO_CNT_W-1:0]; // [R21]
      end else if (ce_i) begin
         if (qclk_edge) begin
            mono_q <= '0; // [R17] [R21]
         end else if (mono_busy) begin
            mono_q <= mono_q + 16'h0001;
         end
      end
   end

   // ==================================================================
   // Pending word and shadow load
   logic pend_q;
   logic load_ps;
   logic [DATA_BITS-1:0] ps_rev;

   assign load_ps = pend_q && !mono_busy; // [R17] [R18]

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         hold_q <= '0;
         pend_q <= 1'b0;
      end else if (ce_i) begin
         if (block_done && crc_good) begin
            hold_q <= sp_q; // [R13]
            pend_q <= 1'b1;
         end else if (load_ps) begin
            pend_q <= 1'b0;
         end
      end
   end

   for (genvar b = 0; b < DATA_BITS / 8; b++) begin : g_byte
      for (genvar i = 0; i < 8; i++) begin : g_bit
         assign ps_rev[8*b+i] = hold_q[8*b+7-i]; // [R14]
      end
   end

   // ==================================================================
   // Q readout state machine
   scrsm_pkg::scrsm_qstate_t qst_q;
   logic [DATA_BITS-1:0] ps_q;
   logic q_data_q;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         qst_q <= scrsm_pkg::SCRSM_Q_IDLE;
      end else if (ce_i) begin
         case (qst_q)
            scrsm_pkg::SCRSM_Q_IDLE: begin
               if (qclk_rise) begin
                  qst_q <= scrsm_pkg::SCRSM_Q_SHIFT;
               end
            end
            scrsm_pkg::SCRSM_Q_SHIFT: begin
               if (load_ps) begin
                  qst_q <= scrsm_pkg::SCRSM_Q_IDLE;
               end
            end
            default: begin
               qst_q <= scrsm_pkg::SCRSM_Q_IDLE;
            end
         endcase
      end
   end

   // Flag before readout, then one data bit per rising edge
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ps_q <= '0;
         q_data_q <= 1'b0;
      end else if (ce_i) begin
         if (load_ps) begin
            ps_q <= ps_rev; // [R13] [R16]
            q_data_q <= 1'b1; // [R13] [R16]
         end else if (qclk_rise) begin
            q_data_q <= ps_q[0];
            ps_q <= {1'b0, ps_q[DATA_BITS-1:1]};
         end
      end
   end

   // ==================================================================
   // Flags towards the host
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         crc_pass_flag_o <= 1'b0;
      end else if (ce_i) begin
         if (load_ps) begin
            crc_pass_flag_o <= 1'b1; // [R13]
         end else if (qclk_rise && qst_q == scrsm_pkg::SCRSM_Q_IDLE) begin
            crc_pass_flag_o <= 1'b0;
         end
      end
   end

   // Set wins over the clear by a shift clock edge
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         subcode_sync_flag_o <= 1'b0;
      end else if (ce_i) begin
         if (q_block_start_i) begin
            subcode_sync_flag_o <= 1'b1;
         end else if (qclk_rise) begin
            subcode_sync_flag_o <= 1'b0;
         end
      end
   end

   // ==================================================================
   // Slot counter for the multiplexed mode
   logic [`SCRSM_SLOT_W-1:0] slot_q;
   logic [3:0] slot_vec;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         slot_q <= '0;
      end else if (ce_i) begin
         if (!mono_busy) begin
            slot_q <= '0;
         end else if (qclk_rise) begin
            slot_q <= slot_q + 2'h1; // [R20]
         end
      end
   end

   assign slot_vec = {pw_serial_out_o, status_select_out_o,
                      crc_pass_flag_o, subcode_sync_flag_o};

   // ==================================================================
   // Q serial output pin routing
   scrsm_pkg::scrsm_outsel_t osel;

   assign osel = scrsm_pkg::scrsm_outsel_t'({out_select_hi_i,
                                            out_select_lo_i});

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q_serial_out_o <= 1'b0;
      end else if (ce_i) begin
         case (osel)
            scrsm_pkg::SCRSM_OUT_PW: begin
               q_serial_out_o <= pw_serial_out_o; // [R11]
            end
            scrsm_pkg::SCRSM_OUT_STATUS: begin
               q_serial_out_o <= status_select_out_o; // [R8]
            end
            scrsm_pkg::SCRSM_OUT_MUX: begin
               q_serial_out_o <= slot_vec[slot_q]; // [R20]
            end
            default: begin
               q_serial_out_o <= q_data_q; // [R15]
            end
         endcase
      end
   end

endmodule

// ==== scrsm_checker.sv ====
// Checker of the subcode readout and status mux.
// Assumes binding into scrsm_top; sees its ports only.
`timescale 1ns/1ps
`include "scrsm_cfg.svh"
module scrsm_checker #(
   parameter int MONO_CYCLES = `SCRSM_MONO_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Block inputs
   input wire logic [3:0] cmd_nibble_i,
   input wire logic out_select_hi_i,
   input wire logic out_select_lo_i,
   input wire logic servo_sense_in_i,
   input wire logic focus_ok_i,
   input wire logic sequencer_busy_n_i,
   input wire logic q_shift_clock_i,
   // Block outputs
   input wire logic status_select_out_o,
   input wire logic pw_serial_out_o,
   input wire logic q_serial_out_o,
   input wire logic crc_pass_flag_o
);
   logic [2:0] up_q;
   logic [15:0] quiet_q;
   logic qck_q, hi_q, lo_q, stat_q;
   wire up = up_q[2];
   wire [3:0] c = cmd_nibble_i;
   wire snd = c < 4'h4 || c == 4'h6;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   // ====================
   // Helpers
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         up_q <= 3'h0;
      end else if (!up_q[2]) begin
         up_q <= up_q + 3'h1;
      end
   end
   always_ff @(posedge clk_i) begin
      hi_q <= out_select_hi_i;
      lo_q <= out_select_lo_i;
      stat_q <= status_select_out_o;
   end
   // Cycles since the last Q clock edge
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         qck_q <= 1'b0;
         quiet_q <= 16'hFFFF;
      end else begin
         qck_q <= q_shift_clock_i;
         if (q_shift_clock_i != qck_q) begin
            quiet_q <= 16'h0000;
         end else if (quiet_q != 16'hFFFF) begin
            quiet_q <= quiet_q + 16'h0001;
         end
      end
   end

   // ====================
   // Properties
   property p_low;
      up && c inside {4'h7, 4'h8, 4'h9, 4'hB, 4'hC, 4'hD, 4'hF}
         |=> !status_select_out_o;
   endproperty
   a_low: assert property (p_low)
      else $error("status not low");
   property p_busy;
      up && c == 4'h4 |=> status_select_out_o == $past(sequencer_busy_n_i);
   endproperty
   a_busy: assert property (p_busy)
      else $error("busy not shown");
   property p_sense;
      up && snd ##0 ($stable(servo_sense_in_i) && $stable(c))[*4]
         |-> status_select_out_o == servo_sense_in_i;
   endproperty
   a_sense: assert property (p_sense)
      else $error("sense not shown");
   property p_focus;
      up && c == 4'h5 ##0 ($stable(focus_ok_i) && $stable(c))[*4]
         |-> status_select_out_o == focus_ok_i;
   endproperty
   a_focus: assert property (p_focus)
      else $error("focus not shown");
   property p_sel10;
      up && hi_q && !lo_q |-> q_serial_out_o == stat_q;
   endproperty
   a_sel10: assert property (p_sel10)
      else $error("status not on q pin");
   property p_sel01;
      up && !hi_q && lo_q && $stable(pw_serial_out_o)
         |-> q_serial_out_o == pw_serial_out_o;
   endproperty
   a_sel01: assert property (p_sel01)
      else $error("pw not on q pin");
   property p_flag;
      $rose(crc_pass_flag_o) && !out_select_hi_i && !out_select_lo_i
         |=> q_serial_out_o;
   endproperty
   a_flag: assert property (p_flag)
      else $error("q pin not high on load");
   property p_mono;
      $rose(crc_pass_flag_o) |-> quiet_q >= MONO_CYCLES;
   endproperty
   a_mono: assert property (p_mono)
      else $error("load inside monostable time");

   c_busy: cover property (up && c == 4'h4 && hi_q && !lo_q);
   c_load: cover property ($rose(crc_pass_flag_o));
   c_pw: cover property (up && lo_q && !hi_q && $changed(pw_serial_out_o));
endmodule

bind scrsm_top scrsm_checker #(.MONO_CYCLES(MONO_CYCLES)) i_scrsm_checker (.*);

// ==== scrsm_host.sv ====
// Host controller model reading subcode serially.
// Assumes the bench calls its tasks; clocks rest low between reads.
`timescale 1ns/1ps
module scrsm_host (
   // Shift clocks
   output logic pw_shift_clock_o,
   output logic q_shift_clock_o,
   // Serial data
   input wire logic pw_serial_out_i,
   input wire logic q_serial_out_i
);
   initial begin
      pw_shift_clock_o = 1'b0;
      q_shift_clock_o = 1'b0;
   end

   // ====================
   // P-W symbol, 48 ns link period, started after frame load
   task automatic read_pw(output logic [7:0] s);
      #7;
      for (int i = 7; i >= 0; i--) begin
         s[i] = pw_serial_out_i;
         pw_shift_clock_o = 1'b1;
         #24;
         pw_shift_clock_o = 1'b0;
         #24;
      end
   endtask

   // ====================
   // One Q clock pulse, pin sampled at the end of the high phase
   task automatic pulse_q(input int half_ns, output logic b);
      q_shift_clock_o = 1'b1;
      #(half_ns);
      b = q_serial_out_i;
      q_shift_clock_o = 1'b0;
      #(half_ns);
   endtask

   // ====================
   // Q word, exactly 80 pulses, phases of half_ns
   task automatic read_q(input int half_ns, output logic [79:0] w);
      for (int k = 0; k < 80; k++) begin
         pulse_q(half_ns, w[k]);
      end
   endtask
endmodule

// ==== scrsm_top_tb.sv ====
// Self-checking bench of the subcode readout and status mux.
// Assumes scrsm_host as the microcontroller, 100 MHz clock.
`timescale 1ns/1ps
`include "scrsm_cfg.svh"
`define CHK(g, e) begin \
   samples_checked++; \
   if ((g) !== (e)) begin \
      fail_count++; \
      $display("mismatch t=%0t got %h exp %h", $time, g, e); \
   end \
end
module scrsm_top_tb;
   localparam int MONO = 200;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [3:0] cmd = 4'h0;
   logic hi = 1'b0, lo = 1'b0;
   logic [4:0] src = 5'h00;
   logic [7:0] pw_sym = 8'h00;
   logic pw_load = 1'b0, q_bit = 1'b0, q_val = 1'b0, q_start = 1'b0;
   logic stat, pw_out, q_out, crc_f, sync_f, pw_ck, q_ck;
   int fail_count = 0;
   int samples_checked = 0;

   scrsm_top #(.MONO_CYCLES(MONO)) i_scrsm_top (
      .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
      .cmd_nibble_i(cmd), .out_select_hi_i(hi), .out_select_lo_i(lo),
      .servo_sense_in_i(src[0]), .focus_ok_i(src[1]),
      .sequencer_busy_n_i(src[2]), .frame_sync_good_i(src[3]),
      .long_pulse_flag_n_i(src[4]), .pw_symbol_i(pw_sym),
      .pw_symbol_load_i(pw_load), .q_bit_i(q_bit), .q_bit_valid_i(q_val),
      .q_block_start_i(q_start), .pw_shift_clock_i(pw_ck),
      .q_shift_clock_i(q_ck), .status_select_out_o(stat),
      .pw_serial_out_o(pw_out), .q_serial_out_o(q_out),
      .crc_pass_flag_o(crc_f), .subcode_sync_flag_o(sync_f));
   scrsm_host i_scrsm_host (
      .pw_shift_clock_o(pw_ck), .q_shift_clock_o(q_ck),
      .pw_serial_out_i(pw_out), .q_serial_out_i(q_out));

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   // ====================
   // Helpers
   function automatic logic exp_stat(input logic [3:0] n,
                                     input logic [4:0] s);
      case (n)
         4'h0, 4'h1, 4'h2, 4'h3, 4'h6: return s[0];
         4'h4: return s[2];
         4'h5: return s[1];
         4'hA: return s[3];
         4'hE: return s[4];
         default: return 1'b0;
      endcase
   endfunction
   function automatic logic [79:0] lsb_first(input logic [79:0] d);
      for (int k = 0; k < 80; k++) begin
         lsb_first[k] = d[72 - 8 * (k / 8) + k % 8];
      end
   endfunction
   task automatic send_q(input logic [79:0] d, input logic bad);
      logic [15:0] crc;
      logic [95:0] blk;
      crc = 16'h0000;
      for (int i = 79; i >= 0; i--) begin
         crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ d[i]) ? 16'h1021 : 16'h0000);
      end
      blk = {d, ~crc ^ {15'h0000, bad}};
      q_start = 1'b1;
      @(negedge clk_i);
      q_start = 1'b0;
      for (int i = 95; i >= 0; i--) begin
         q_bit = blk[i];
         q_val = 1'b1;
         @(negedge clk_i);
         q_val = 1'b0;
         @(negedge clk_i);
      end
   endtask
   task automatic wait_flag(input int lim, output logic seen);
      seen = 1'b0;
      for (int i = 0; i < lim && !seen; i++) begin
         @(negedge clk_i);
         seen = crc_f;
      end
   endtask
   task automatic give_verdict();
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ====================
   // Scenarios
   task automatic t_status();
      {hi, lo} = 2'b10;
      for (int p = 0; p < 2; p++) begin
         src = p ? 5'h0A : 5'h15;
         repeat (5) @(negedge clk_i);
         for (int n = 0; n < 16; n++) begin
            cmd = n[3:0];
            @(negedge clk_i);
            `CHK(stat, exp_stat(cmd, src))
            @(negedge clk_i);
            `CHK(q_out, exp_stat(cmd, src))
            repeat (4) @(negedge clk_i);
         end
      end
   endtask
   task automatic t_pw(input logic [7:0] sym);
      logic [7:0] s;
      @(negedge clk_i);
      {hi, lo} = 2'b01;
      pw_sym = sym;
      pw_load = 1'b1;
      @(negedge clk_i);
      pw_load = 1'b0;
      repeat (3) @(negedge clk_i);
      `CHK(q_out, sym[7])
      i_scrsm_host.read_pw(s);
      `CHK(s, sym)
   endtask
   task automatic t_qread();
      logic seen;
      logic [79:0] w;
      @(negedge clk_i);
      {hi, lo} = 2'b00;
      send_q(80'h0123_4567_89AB_CDEF_0F1E, 1'b0);
      wait_flag(50, seen);
      `CHK(seen, 1'b1)
      @(negedge clk_i);
      `CHK(q_out, 1'b1)
      fork
         i_scrsm_host.read_q(800, w);
         begin
            repeat (1000) @(negedge clk_i);
            send_q(80'hFEDC_BA98_7654_3210_A5C3, 1'b0);
         end
      join
      `CHK(w, lsb_first(80'h0123_4567_89AB_CDEF_0F1E))
      @(negedge clk_i);
      repeat (MONO - 100) @(negedge clk_i);
      `CHK(crc_f, 1'b0)
      wait_flag(150, seen);
      `CHK(seen, 1'b1)
      i_scrsm_host.read_q(800, w);
      `CHK(w, lsb_first(80'hFEDC_BA98_7654_3210_A5C3))
      @(negedge clk_i);
      send_q(80'h1111_2222_3333_4444_5555, 1'b1);
      wait_flag(MONO + 50, seen);
      `CHK(seen, 1'b0)
   endtask
   // Mode 11: sync flag, CRC flag, status, P-W bit in slot order
   task automatic t_mux();
      logic [3:0] v;
      @(negedge clk_i);
      {hi, lo} = 2'b11;
      cmd = 4'h5;
      pw_sym = 8'h80;
      pw_load = 1'b1;
      @(negedge clk_i);
      pw_load = 1'b0;
      repeat (8) @(negedge clk_i);
      `CHK(sync_f, 1'b1)
      `CHK(q_out, 1'b1)
      for (int k = 0; k < 4; k++) begin
         i_scrsm_host.pulse_q(800, v[k]);
      end
      `CHK(v, 4'hC)
      `CHK(sync_f, 1'b0)
   endtask

   initial begin
      repeat (20) @(negedge clk_i);
      resetn_i = 1'b1;
      repeat (3) @(negedge clk_i);
      t_status();
      t_pw(8'hA5);
      t_pw(8'h3C);
      t_qread();
      t_mux();
      give_verdict();
   end
   initial begin
      #600000;
      fail_count++;
      give_verdict();
   end
endmodule
